// ---- mfc_pkg.sv ----
// modem frequency config: offsets, reset values, field layout, types
package mfc_pkg;

  localparam int MFC_AW = 6;
  localparam int MFC_DW = 8;

  // register offsets
  localparam logic [5:0] MFC_OFS_CARRIER_WORD_A_MID = 6'h0e;
  localparam logic [5:0] MFC_OFS_CARRIER_WORD_A_LOW = 6'h0f;
  localparam logic [5:0] MFC_OFS_BW_RATE = 6'h10;
  localparam logic [5:0] MFC_OFS_SYM_MANT = 6'h11;
  localparam logic [5:0] MFC_OFS_MOD_CODE = 6'h12;

  // values after reset
  localparam logic [7:0] MFC_RST_CARRIER_WORD_A_MID = 8'hc4;
  localparam logic [7:0] MFC_RST_CARRIER_WORD_A_LOW = 8'hec;
  localparam logic [7:0] MFC_RST_BW_RATE = 8'h8c;
  localparam logic [7:0] MFC_RST_SYM_MANT = 8'h22;
  localparam logic [7:0] MFC_RST_MOD_CODE = 8'h00;

  // field positions
  localparam int MFC_BW_E_HI = 7;
  localparam int MFC_BW_E_LO = 6;
  localparam int MFC_BW_M_HI = 5;
  localparam int MFC_BW_M_LO = 4;
  localparam int MFC_SR_E_HI = 3;
  localparam int MFC_DCF_BIT = 7;
  localparam int MFC_MOD_HI = 6;
  localparam int MFC_MOD_LO = 4;
  localparam int MFC_MAN_BIT = 3;

  // decimation arithmetic, symbol-rate accumulator, async packet format code
  localparam logic [8:0] MFC_DEC_SCALE = 9'h008;
  localparam logic [8:0] MFC_DEC_BASE = 9'h004;
  localparam logic [8:0] MFC_RATE_HIDDEN = 9'h100;
  localparam int MFC_RATE_ACC_W = 28;
  localparam logic [1:0] MFC_PKT_ASYNC = 2'h3;

  // modulation field codes
  localparam logic [2:0] MFC_CODE_2FSK = 3'h0;
  localparam logic [2:0] MFC_CODE_GFSK = 3'h1;
  localparam logic [2:0] MFC_CODE_OOK = 3'h3;
  localparam logic [2:0] MFC_CODE_4FSK = 3'h4;

  typedef enum logic [2:0] {
    MFC_MOD_2FSK,
    MFC_MOD_GFSK,
    MFC_MOD_OOK,
    MFC_MOD_4FSK
  } mfc_mod_e;

  typedef struct packed {
    logic [23:0] carrier_word;
    logic [1:0] chan_bw_exponent;
    logic [1:0] chan_bw_mantissa;
    logic [8:0] decim_ratio;
    logic [3:0] symbol_rate_exp;
    logic [7:0] symbol_rate_mant;
    logic dc_block_enable;
    mfc_mod_e modulation_select;
    logic modulation_reserved;
    logic manchester_en;
  } mfc_cfg_s;

  localparam mfc_cfg_s MFC_CFG_RST = '{
    carrier_word: 24'h00c4ec,
    chan_bw_exponent: 2'h2,
    chan_bw_mantissa: 2'h0,
    decim_ratio: 9'h080,
    symbol_rate_exp: 4'hc,
    symbol_rate_mant: 8'h22,
    dc_block_enable: 1'b1,
    modulation_select: MFC_MOD_2FSK,
    modulation_reserved: 1'b0,
    manchester_en: 1'b0
  };

endpackage

// ---- mfc_rate_nco.sv ----
// symbol-rate accumulator: one tick per symbol period
`timescale 1ns/1ps
module mfc_rate_nco
  import mfc_pkg::*;
#(
  parameter int ACC_W = MFC_RATE_ACC_W
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // rate setting
  input wire logic [7:0] mant_i,
  input wire logic [3:0] exp_i,
  // symbol strobe
  output logic tick_o
);

  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] next_acc;
  logic next_tick;
  logic [ACC_W:0] sum;
  logic [ACC_W-1:0] inc;

  // (256 + mant) << exp, overflow of 2^ACC_W marks a symbol
  always_comb begin
    inc = ACC_W'({MFC_RATE_HIDDEN[8], mant_i}) << exp_i;
    sum = {1'b0, acc} + {1'b0, inc};
    next_acc = sum[ACC_W-1:0];
    next_tick = sum[ACC_W];
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc <= '0;
      tick_o <= 1'b0;
    end else begin
      acc <= next_acc;
      tick_o <= next_tick;
    end
  end

  property p_tick_on_wrap;
    @(posedge core_clk_i) disable iff (!rstn_i)
    tick_o == $past(sum[ACC_W]);
  endproperty
  a_tick_on_wrap: assert property (p_tick_on_wrap)
    else $error("symbol tick not tied to accumulator wrap");

endmodule

// ---- mfc_regs.sv ----
// modem frequency and modulation configuration register bank
// Operation
// - offset 0x0e holds carrier word bits 15:8, read/write, reset 0xc4
// - offset 0x0f holds carrier word bits 7:0, read/write, reset 0xec
// - bandwidth exponent 7:6, mantissa 5:4 set decimation 8*(4+m)*2^e
// - symbol-rate exponent in bits 3:0, read/write, reset 12
// - symbol rate is (256+mantissa)*2^exp/2^28 times the reference clock
// - offset 0x11 holds symbol-rate mantissa, read/write, reset 0x22
// - bit 7 set bypasses dc blocking; host bypasses only up to 250 kBaud
// - modulation 000 2-FSK, 001 GFSK, 011 OOK, 100 4-FSK, rest reserved
// - 24-bit carrier word is the base frequency in clock/2^16 steps
// - packet format code 11 means asynchronous serial operation
`timescale 1ns/1ps
module mfc_regs
  import mfc_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // register access from the serial interface logic
  input wire logic [5:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // neighbouring configuration
  input wire logic [5:0] carrier_word_a_high_i,
  input wire logic [1:0] packet_format_select_i,
  // modem datapath
  output mfc_cfg_s cfg_o,
  output logic symbol_tick_o,
  output logic coding_conflict_o
);

  ////////////////////////////////////////////////////////////////////////////
  // storage

  logic [7:0] carrier_carrier_word_a_mid_byte;
  logic [7:0] carrier_carrier_word_a_low_byte;
  logic [7:0] bandwidth_rate_exp_cfg;
  logic [7:0] symbol_rate_mantissa;
  logic [7:0] modulation_coding_cfg;
  logic [7:0] next_carrier_carrier_word_a_mid_byte;
  logic [7:0] next_carrier_carrier_word_a_low_byte;
  logic [7:0] next_bandwidth_rate_exp_cfg;
  logic [7:0] next_symbol_rate_mantissa;
  logic [7:0] next_modulation_coding_cfg;
  logic [7:0] next_reg_rdata;
  logic next_reg_rvalid;

  function automatic logic wr_hit(input logic [5:0] ofs);
    return reg_wr_i && (reg_addr_i == ofs);
  endfunction

  always_comb begin
    next_carrier_carrier_word_a_mid_byte = carrier_carrier_word_a_mid_byte;
    next_carrier_carrier_word_a_low_byte = carrier_carrier_word_a_low_byte;
    next_bandwidth_rate_exp_cfg = bandwidth_rate_exp_cfg;
    next_symbol_rate_mantissa = symbol_rate_mantissa;
    next_modulation_coding_cfg = modulation_coding_cfg;
    if (wr_hit(MFC_OFS_CARRIER_WORD_A_MID)) begin
      next_carrier_carrier_word_a_mid_byte = reg_wdata_i;
    end
    if (wr_hit(MFC_OFS_CARRIER_WORD_A_LOW)) begin
      next_carrier_carrier_word_a_low_byte = reg_wdata_i;
    end
    if (wr_hit(MFC_OFS_BW_RATE)) begin
      next_bandwidth_rate_exp_cfg = reg_wdata_i;
    end
    if (wr_hit(MFC_OFS_SYM_MANT)) begin
      next_symbol_rate_mantissa = reg_wdata_i;
    end
    // low three bits belong to the sync-mode field kept elsewhere
    if (wr_hit(MFC_OFS_MOD_CODE)) begin
      next_modulation_coding_cfg = {reg_wdata_i[7:3], 3'h0};
    end
    // read data; unmapped offsets answer zero
    next_reg_rvalid = reg_rd_i;
    case (reg_addr_i)
      MFC_OFS_CARRIER_WORD_A_MID: next_reg_rdata = carrier_carrier_word_a_mid_byte;
      MFC_OFS_CARRIER_WORD_A_LOW: next_reg_rdata = carrier_carrier_word_a_low_byte;
      MFC_OFS_BW_RATE: next_reg_rdata = bandwidth_rate_exp_cfg;
      MFC_OFS_SYM_MANT: next_reg_rdata = symbol_rate_mantissa;
      MFC_OFS_MOD_CODE: next_reg_rdata = modulation_coding_cfg;
      default: next_reg_rdata = 8'h00;
    endcase
    if (!reg_rd_i) begin
      next_reg_rdata = reg_rdata_o;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      carrier_carrier_word_a_mid_byte <= MFC_RST_CARRIER_WORD_A_MID;
      carrier_carrier_word_a_low_byte <= MFC_RST_CARRIER_WORD_A_LOW;
      bandwidth_rate_exp_cfg <= MFC_RST_BW_RATE;
      symbol_rate_mantissa <= MFC_RST_SYM_MANT;
      modulation_coding_cfg <= MFC_RST_MOD_CODE;
      reg_rdata_o <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      carrier_carrier_word_a_mid_byte <= next_carrier_carrier_word_a_mid_byte;
      carrier_carrier_word_a_low_byte <= next_carrier_carrier_word_a_low_byte;
      bandwidth_rate_exp_cfg <= next_bandwidth_rate_exp_cfg;
      symbol_rate_mantissa <= next_symbol_rate_mantissa;
      modulation_coding_cfg <= next_modulation_coding_cfg;
      reg_rdata_o <= next_reg_rdata;
      reg_rvalid_o <= next_reg_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded configuration for the datapath

  mfc_cfg_s next_cfg;
  logic next_conflict;

  // 8 * (4 + m) * 2^e, at most 448
  function automatic logic [8:0] decim(input logic [1:0] m,
                                       input logic [1:0] e);
    return ((MFC_DEC_BASE + 9'(m)) * MFC_DEC_SCALE) << e;
  endfunction

  function automatic mfc_mod_e mod_decode(input logic [2:0] code);
    case (code)
      MFC_CODE_GFSK: return MFC_MOD_GFSK;
      MFC_CODE_OOK: return MFC_MOD_OOK;
      MFC_CODE_4FSK: return MFC_MOD_4FSK;
      default: return MFC_MOD_2FSK;
    endcase
  endfunction

  logic [2:0] mod_code;
  logic [1:0] bw_m;
  logic [1:0] bw_e;

  always_comb begin
    mod_code = modulation_coding_cfg[MFC_MOD_HI:MFC_MOD_LO];
    bw_e = bandwidth_rate_exp_cfg[MFC_BW_E_HI:MFC_BW_E_LO];
    bw_m = bandwidth_rate_exp_cfg[MFC_BW_M_HI:MFC_BW_M_LO];
    next_cfg.carrier_word = {2'h0, carrier_word_a_high_i, carrier_carrier_word_a_mid_byte,
                             carrier_carrier_word_a_low_byte};
    next_cfg.chan_bw_exponent = bw_e;
    next_cfg.chan_bw_mantissa = bw_m;
    next_cfg.decim_ratio = decim(bw_m, bw_e);
    next_cfg.symbol_rate_exp =
      bandwidth_rate_exp_cfg[MFC_SR_E_HI:0];
    next_cfg.symbol_rate_mant = symbol_rate_mantissa;
    next_cfg.dc_block_enable = !modulation_coding_cfg[MFC_DCF_BIT];
    next_cfg.modulation_select = mod_decode(mod_code);
    // reserved codes run as 2-FSK but are flagged to the datapath
    next_cfg.modulation_reserved = !(mod_code inside {MFC_CODE_2FSK,
      MFC_CODE_GFSK, MFC_CODE_OOK, MFC_CODE_4FSK});
    next_cfg.manchester_en = modulation_coding_cfg[MFC_MAN_BIT];
    // the host is trusted, so a bad mix is only reported, not corrected
    next_conflict = modulation_coding_cfg[MFC_MAN_BIT] &&
      ((mod_code == MFC_CODE_4FSK) ||
       (packet_format_select_i == MFC_PKT_ASYNC));
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_o <= MFC_CFG_RST;
      coding_conflict_o <= 1'b0;
    end else begin
      cfg_o <= next_cfg;
      coding_conflict_o <= next_conflict;
    end
  end

  mfc_rate_nco u_rate_nco (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .mant_i(symbol_rate_mantissa),
    .exp_i(bandwidth_rate_exp_cfg[MFC_SR_E_HI:0]),
    .tick_o(symbol_tick_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks

  property p_mid_write;
    @(posedge core_clk_i) disable iff (!rstn_i)
    wr_hit(MFC_OFS_CARRIER_WORD_A_MID) |=> ##1 cfg_o.carrier_word[15:8] ==
      $past(reg_wdata_i, 2);
  endproperty
  a_mid_write: assert property (p_mid_write)
    else $error("carrier middle byte not updated");

  property p_low_write;
    @(posedge core_clk_i) disable iff (!rstn_i)
    wr_hit(MFC_OFS_CARRIER_WORD_A_LOW) |=> ##1 cfg_o.carrier_word[7:0] ==
      $past(reg_wdata_i, 2);
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("carrier low byte not updated");

  property p_decim;
    @(posedge core_clk_i) disable iff (!rstn_i)
    wr_hit(MFC_OFS_BW_RATE) && !reg_wdata_i[5] && !reg_wdata_i[7]
      |=> ##1 cfg_o.decim_ratio == ((9'h020 + ($past(reg_wdata_i[4], 2)
      ? 9'h008 : 9'h000)) << $past(reg_wdata_i[6], 2));
  endproperty
  a_decim: assert property (p_decim)
    else $error("decimation ratio wrong");

  property p_rate_exp;
    @(posedge core_clk_i) disable iff (!rstn_i)
    wr_hit(MFC_OFS_BW_RATE) ##1 !wr_hit(MFC_OFS_BW_RATE)
      |=> cfg_o.symbol_rate_exp == $past(reg_wdata_i[3:0], 2);
  endproperty
  a_rate_exp: assert property (p_rate_exp)
    else $error("symbol-rate exponent lost");

  property p_mant_read;
    @(posedge core_clk_i) disable iff (!rstn_i)
    wr_hit(MFC_OFS_SYM_MANT) ##1 (reg_rd_i && !reg_wr_i &&
      reg_addr_i == MFC_OFS_SYM_MANT)
      |=> reg_rvalid_o && reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_mant_read: assert property (p_mant_read)
    else $error("mantissa readback wrong");

  property p_dc_block;
    @(posedge core_clk_i) disable iff (!rstn_i)
    wr_hit(MFC_OFS_MOD_CODE) |=> ##1 cfg_o.dc_block_enable !=
      $past(reg_wdata_i[7], 2);
  endproperty
  a_dc_block: assert property (p_dc_block)
    else $error("dc blocking polarity wrong");

  property p_mod_4fsk;
    @(posedge core_clk_i) disable iff (!rstn_i)
    wr_hit(MFC_OFS_MOD_CODE) && reg_wdata_i[6:4] == 3'h4 |=> ##1
      cfg_o.modulation_select == MFC_MOD_4FSK && !cfg_o.modulation_reserved;
  endproperty
  a_mod_4fsk: assert property (p_mod_4fsk)
    else $error("4-FSK not decoded");

  property p_mod_reserved;
    @(posedge core_clk_i) disable iff (!rstn_i)
    wr_hit(MFC_OFS_MOD_CODE) && reg_wdata_i[6:4] == 3'h2 |=> ##1
      cfg_o.modulation_reserved;
  endproperty
  a_mod_reserved: assert property (p_mod_reserved)
    else $error("reserved modulation not flagged");

  property p_async_conflict;
    @(posedge core_clk_i) disable iff (!rstn_i)
    modulation_coding_cfg[3] && packet_format_select_i == 2'h3
      |=> coding_conflict_o;
  endproperty
  a_async_conflict: assert property (p_async_conflict)
    else $error("async serial with coding not reported");

endmodule

// ---- testbench.sv ----
// self-checking bench for the modem frequency config register bank
`timescale 1ns/1ps
module testbench;
  import mfc_pkg::*;
  typedef struct {logic [5:0] a; logic [7:0] w; logic [7:0] r;} mfc_row_s;
  logic core_clk_i, rstn_i, reg_wr_i, reg_rd_i, reg_rvalid_o;
  logic symbol_tick_o, coding_conflict_o;
  logic [5:0] reg_addr_i, carrier_word_a_high_i;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic [1:0] packet_format_select_i;
  mfc_cfg_s cfg_o;
  int mismatches, comparisons, ticks;
  // write, readback; unmapped places answer 00, low bits of 0x12 drop
  mfc_row_s rows[7] = '{'{6'h0e, 8'h5a, 8'h5a}, '{6'h0f, 8'ha5, 8'ha5},
    '{6'h10, 8'h3c, 8'h3c}, '{6'h11, 8'hff, 8'hff}, '{6'h12, 8'hff, 8'hf8},
    '{6'h13, 8'h77, 8'h00}, '{6'h3f, 8'h66, 8'h00}};
  mfc_mod_e mods[8] = '{MFC_MOD_2FSK, MFC_MOD_GFSK, MFC_MOD_2FSK, MFC_MOD_OOK,
    MFC_MOD_4FSK, MFC_MOD_2FSK, MFC_MOD_2FSK, MFC_MOD_2FSK};

  mfc_regs dut (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .carrier_word_a_high_i(carrier_word_a_high_i),
    .packet_format_select_i(packet_format_select_i),
    .cfg_o(cfg_o), .symbol_tick_o(symbol_tick_o),
    .coding_conflict_o(coding_conflict_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // returns once cfg_o has taken the new value, two edges after the strobe
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rvalid_o, 1'b1);
    chk(reg_rdata_o, e);
  endtask

  // counts strobes over a window that holds a whole number of wraps
  task automatic count_ticks(input int n, input int exp);
    ticks = 0;
    repeat (n) begin
      @(posedge core_clk_i);
      #1;
      if (symbol_tick_o === 1'b1) ticks++;
    end
    chk(ticks, exp);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 6'h00;
    reg_wdata_i = 8'h00;
    carrier_word_a_high_i = 6'h00;
    packet_format_select_i = 2'h0;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk(cfg_o, MFC_CFG_RST);
    chk({symbol_tick_o, coding_conflict_o, reg_rvalid_o}, 3'h0);
    @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(MFC_OFS_CARRIER_WORD_A_MID, 8'hc4);
    rd(MFC_OFS_CARRIER_WORD_A_LOW, 8'hec);
    rd(MFC_OFS_BW_RATE, 8'h8c);
    rd(MFC_OFS_SYM_MANT, 8'h22);
    rd(MFC_OFS_MOD_CODE, 8'h00);
    $display("test reset values done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].r);
    end
    $display("test register rows done");
    carrier_word_a_high_i <= 6'h1e;
    wr(MFC_OFS_CARRIER_WORD_A_MID, 8'h12);
    wr(MFC_OFS_CARRIER_WORD_A_LOW, 8'h34);
    chk(cfg_o.carrier_word, 24'h1e1234);
    $display("test carrier word done");
    for (int e = 0; e < 4; e++) begin
      for (int m = 0; m < 4; m++) begin
        wr(MFC_OFS_BW_RATE, {e[1:0], m[1:0], 4'h5});
        chk(cfg_o.decim_ratio, (8 * (4 + m)) << e);
        chk({cfg_o.chan_bw_exponent, cfg_o.chan_bw_mantissa,
          cfg_o.symbol_rate_exp}, {e[1:0], m[1:0], 4'h5});
      end
    end
    $display("test decimation done");
    for (int c = 0; c < 8; c++) begin
      wr(MFC_OFS_MOD_CODE, {1'b1, c[2:0], 4'h0});
      chk(cfg_o.modulation_select, mods[c]);
      chk(cfg_o.modulation_reserved, !(c inside {0, 1, 3, 4}));
      chk(cfg_o.dc_block_enable, 1'b0);
    end
    $display("test modulation codes done");
    // host rules broken on purpose here to exercise the conflict report
    wr(MFC_OFS_MOD_CODE, 8'h48);
    chk({cfg_o.manchester_en, coding_conflict_o}, 2'h3);
    wr(MFC_OFS_MOD_CODE, 8'h08);
    chk({cfg_o.dc_block_enable, coding_conflict_o}, 2'h2);
    @(posedge core_clk_i);
    packet_format_select_i <= MFC_PKT_ASYNC;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk(coding_conflict_o, 1'b1);
    @(posedge core_clk_i);
    packet_format_select_i <= 2'h1;
    repeat (2) @(posedge core_clk_i);
    #1;
    chk(coding_conflict_o, 1'b0);
    $display("test coding conflict done");
    // exact periods only: 32 and 128/3 cycles, so no phase slack needed
    wr(MFC_OFS_SYM_MANT, 8'h00);
    wr(MFC_OFS_BW_RATE, 8'h0f);
    count_ticks(320, 10);
    wr(MFC_OFS_SYM_MANT, 8'h80);
    chk(cfg_o.symbol_rate_mant, 8'h80);
    wr(MFC_OFS_BW_RATE, 8'h0e);
    count_ticks(1280, 30);
    $display("test symbol rate done");
    @(posedge core_clk_i);
    reg_addr_i <= MFC_OFS_SYM_MANT;
    reg_wdata_i <= 8'h99;
    reg_wr_i <= 1'b1;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, 8'h80);
    rd(MFC_OFS_SYM_MANT, 8'h99);
    // write straight followed by a read of the same place
    @(posedge core_clk_i);
    reg_wdata_i <= 8'h3d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, 8'h3d);
    $display("test read during write done");
    @(posedge core_clk_i);
    rstn_i <= 1'b0;
    #1;
    chk(cfg_o, MFC_CFG_RST);
    @(posedge core_clk_i);
    rstn_i <= 1'b1;
    rd(MFC_OFS_SYM_MANT, 8'h22);
    rd(MFC_OFS_MOD_CODE, 8'h00);
    $display("test second reset done");
    conclude();
  end

  // whole sequence needs about 1760 cycles
  initial begin
    #200000;
    mismatches++;
    $display("ERROR at %0t: run did not finish", $time);
    conclude();
  end
endmodule
